// ---- design/liu_rx_path.v ----
// Receive path back end of one line interface channel with jitter attenuator.
`timescale 1ns/1ns
`default_nettype none
`include "liu_rx_defines.vh"
module liu_rx_path (
    input wire CLK_I,
    input wire RST_I,
    input wire [7:0] REG_ADDR_I,
    input wire REG_WR_I,
    input wire [7:0] REG_WDATA_I,
    output reg [7:0] REG_RDATA_O,
    input wire E1_MODE_I,
    input wire LINE_CLK_I,
    input wire LINE_POS_I,
    input wire LINE_NEG_I,
    input wire MCLK_I,
    input wire LOS_DETECT_I,
    input wire [5:0] MONITOR_CLK_I,
    input wire [5:0] MONITOR_POS_I,
    input wire [5:0] MONITOR_NEG_I,
    output reg RX_RECOVERED_CLOCK_O,
    output reg RX_DATA_POSITIVE_O,
    output reg RX_DATA_NEGATIVE_O,
    output reg SIGNAL_LOSS_OUT_O,
    output reg FIRST_CHANNEL_TX_POS_O,
    output reg FIRST_CHANNEL_TX_NEG_O,
    output reg RX_TERM_INTERNAL_O,
    output reg [1:0] RX_TERM_IMPEDANCE_O,
    output reg [1:0] MONITOR_BOOST_SEL_O,
    output reg EQUALIZER_ENABLE_O,
    output reg [4:0] LOS_LEVEL_O,
    output reg [1:0] SLICER_THRESHOLD_SEL_O,
    output reg RX_POWER_DOWN_O
);
    // ==========================================================
    // Constants and helpers
    localparam [63:0] INC_E1_W = `E1_RATE_HZ * `NCO_ONE / `CLK_HZ;
    localparam [63:0] INC_T1_W = `T1_RATE_HZ * `NCO_ONE / `CLK_HZ;

    function [7:0] ja_depth;
        input [1:0] sel;
        begin
            case (sel)
                `DEPTH_SEL_32: ja_depth = `DEPTH_32;
                `DEPTH_SEL_64: ja_depth = `DEPTH_64;
                default: ja_depth = `DEPTH_128;
            endcase
        end
    endfunction

    function [7:0] ja_margin;
        input [1:0] sel;
        begin
            case (sel)
                `DEPTH_SEL_32: ja_margin = `MARGIN_32;
                `DEPTH_SEL_64: ja_margin = `MARGIN_64;
                default: ja_margin = `MARGIN_128;
            endcase
        end
    endfunction

    // ==========================================================
    // Registers
    reg [7:0] ja_cfg_ff;
    reg [7:0] rx_cfg0_ff;
    reg [7:0] rx_cfg1_ff;
    reg [7:0] rx_cfg2_ff;
    reg [7:0] maint_ff;
    reg [7:0] imp_ff;
    reg [7:0] gcfg1_ff;
    reg ovf_ff;
    reg udf_ff;
    reg [7:0] nxt_rdata;
    wire ovf_evt;
    wire udf_evt;
    wire wr_int = REG_WR_I && (REG_ADDR_I == `ADDR_INT_STAT1);

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            ja_cfg_ff <= `REG_RST;
            rx_cfg0_ff <= `REG_RST;
            rx_cfg1_ff <= `REG_RST;
            rx_cfg2_ff <= `REG_RST;
            maint_ff <= `REG_RST;
            imp_ff <= `REG_RST;
            gcfg1_ff <= `REG_RST;
            ovf_ff <= 1'b0;
            udf_ff <= 1'b0;
            REG_RDATA_O <= `REG_RST;
        end
        else
        begin
            if (REG_WR_I)
            begin
                case (REG_ADDR_I)
                    `ADDR_JA_CFG: ja_cfg_ff <= REG_WDATA_I;
                    `ADDR_RX_CFG0: rx_cfg0_ff <= REG_WDATA_I;
                    `ADDR_RX_CFG1: rx_cfg1_ff <= REG_WDATA_I;
                    `ADDR_RX_CFG2: rx_cfg2_ff <= REG_WDATA_I;
                    `ADDR_MAINT: maint_ff <= REG_WDATA_I;
                    `ADDR_LINE_IMP: imp_ff <= REG_WDATA_I;
                    `ADDR_GLOBAL_CFG1: gcfg1_ff <= REG_WDATA_I;
                    default: ja_cfg_ff <= ja_cfg_ff;
                endcase
            end
            // A new event in the clearing cycle wins over the clear.
            ovf_ff <= ovf_evt | (ovf_ff & ~(wr_int & REG_WDATA_I[`INT_OVF]));
            udf_ff <= udf_evt | (udf_ff & ~(wr_int & REG_WDATA_I[`INT_UDF]));
            REG_RDATA_O <= nxt_rdata;
        end
    end

    always @*
    begin
        case (REG_ADDR_I)
            `ADDR_JA_CFG: nxt_rdata = ja_cfg_ff;
            `ADDR_RX_CFG0: nxt_rdata = rx_cfg0_ff;
            `ADDR_RX_CFG1: nxt_rdata = rx_cfg1_ff;
            `ADDR_RX_CFG2: nxt_rdata = rx_cfg2_ff;
            `ADDR_MAINT: nxt_rdata = maint_ff;
            `ADDR_INT_STAT1: nxt_rdata = {6'h00, udf_ff, ovf_ff};
            `ADDR_LINE_IMP: nxt_rdata = imp_ff;
            `ADDR_GLOBAL_CFG1: nxt_rdata = gcfg1_ff;
            default: nxt_rdata = 8'h00;
        endcase
    end

    wire [1:0] dec_mode = rx_cfg0_ff[`RCFG0_MODE];
    wire data_inv = rx_cfg0_ff[`RCFG0_INV];
    wire edge_rise = rx_cfg0_ff[`RCFG0_EDGE];
    wire power_down = rx_cfg0_ff[`RCFG0_OFF];
    wire bypass = (dec_mode == `MODE_BYPASS);
    wire dual_rail = dec_mode[`MODE_RAIL_BIT];
    wire alarm_ones = maint_ff[`MAINT_ALARM_ONES];
    wire remote_loop = maint_ff[`MAINT_REMOTE_LOOP];
    wire [3:0] monitor_sel = gcfg1_ff[`GCFG1_MONITOR];

    // ==========================================================
    // Input synchronisers
    reg [`SYNC_W-1:0] sync1_ff;
    reg [`SYNC_W-1:0] sync2_ff;

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            sync1_ff <= {`SYNC_W{1'b0}};
            sync2_ff <= {`SYNC_W{1'b0}};
        end
        else
        begin
            sync1_ff <= {LINE_CLK_I, LINE_POS_I, LINE_NEG_I, MCLK_I, LOS_DETECT_I,
                         MONITOR_CLK_I, MONITOR_POS_I, MONITOR_NEG_I};
            sync2_ff <= sync1_ff;
        end
    end

    wire line_clk_s = sync2_ff[22];
    wire line_pos_s = sync2_ff[21];
    wire line_neg_s = sync2_ff[20];
    wire mclk_s = sync2_ff[19];
    wire los_s = sync2_ff[18];
    wire [5:0] mon_clk_s = sync2_ff[17:12];
    wire [5:0] mon_pos_s = sync2_ff[11:6];
    wire [5:0] mon_neg_s = sync2_ff[5:0];

    // ==========================================================
    // Source selection and line timing
    wire monitor_on = (monitor_sel >= `MONITOR_FIRST) && (monitor_sel <= `MONITOR_LAST);
    wire [2:0] monitor_idx = monitor_sel[2:0] - `MONITOR_BASE;
    wire src_clk = monitor_on ? mon_clk_s[monitor_idx] : line_clk_s;
    wire src_pos = monitor_on ? mon_pos_s[monitor_idx] : line_pos_s;
    wire src_neg = monitor_on ? mon_neg_s[monitor_idx] : line_neg_s;
    reg src_clk_d_ff;
    // The line timing keeps the clock running even when no marks arrive.
    wire line_rise = src_clk & ~src_clk_d_ff;

    // ==========================================================
    // Jitter attenuator FIFO and read clock oscillator
    reg [1:0] ja_mem_ff [0:127];
    reg [7:0] wp_ff;
    reg [7:0] rp_ff;
    reg [23:0] acc_ff;
    reg phase_d_ff;
    reg [7:0] nxt_wp;
    reg [7:0] nxt_rp;
    reg [7:0] gain;
    reg signed [24:0] limit_adj;
    wire ja_on = (ja_cfg_ff[`JA_PLACE] == `JA_PLACE_RX) && !bypass;
    wire [7:0] depth = ja_depth(ja_cfg_ff[`JA_DEPTH]);
    wire [7:0] margin = ja_margin(ja_cfg_ff[`JA_DEPTH]);
    wire [7:0] half = {1'b0, depth[7:1]};
    wire [7:0] mask = depth - 8'h01;
    wire [7:0] fill = wp_ff - rp_ff;
    wire full = (fill >= depth);
    wire empty = (fill == 8'h00);
    wire phase = ja_on ? acc_ff[23] : src_clk;
    wire sym_rise = phase & ~phase_d_ff;
    wire sym_fall = ~phase & phase_d_ff;
    wire wr_stb = ja_on & line_rise;
    wire rd_stb = ja_on & sym_rise;
    wire [1:0] ja_rd = empty ? 2'h0 : ja_mem_ff[rp_ff[6:0] & mask[6:0]];
    wire signed [8:0] fill_err = $signed({1'b0, fill}) - $signed({1'b0, half});
    wire signed [17:0] corr = $signed({{9{fill_err[8]}}, fill_err}) * $signed({10'h000, gain});
    wire [23:0] nominal = E1_MODE_I ? INC_E1_W[23:0] : INC_T1_W[23:0];
    wire signed [24:0] inc = $signed({1'b0, nominal}) + {{7{corr[17]}}, corr} + limit_adj;
    assign ovf_evt = wr_stb & full;
    assign udf_evt = rd_stb & empty;

    always @*
    begin
        case ({E1_MODE_I, ja_cfg_ff[`JA_BW]})
            2'h0: gain = `GAIN_T1_NARROW;
            2'h1: gain = `GAIN_T1_WIDE;
            2'h2: gain = `GAIN_E1_NARROW;
            default: gain = `GAIN_E1_WIDE;
        endcase
        limit_adj = 25'h0000000;
        if (ja_cfg_ff[`JA_CLAMP_BIT] && (fill + margin >= depth))
        begin
            limit_adj = `LIMIT_STEP;
        end
        else if (ja_cfg_ff[`JA_CLAMP_BIT] && (fill <= margin))
        begin
            limit_adj = -`LIMIT_STEP;
        end
        nxt_wp = wp_ff;
        nxt_rp = wp_ff - half;
        if (ja_on)
        begin
            nxt_rp = rp_ff;
            if (wr_stb)
            begin
                nxt_wp = wp_ff + 8'h01;
            end
            if (ovf_evt || udf_evt)
            begin
                nxt_rp = nxt_wp - half;
            end
            else if (rd_stb)
            begin
                nxt_rp = rp_ff + 8'h01;
            end
        end
    end

    // Storage has no reset; just after the attenuator is switched on, the half depth behind the write pointer is read before it is written.
    always @(posedge CLK_I)
    begin
        if (wr_stb)
        begin
            ja_mem_ff[wp_ff[6:0] & mask[6:0]] <= {src_pos, src_neg};
        end
    end

    // ==========================================================
    // Decoder
    wire dec_data;
    wire dec_cv;
    wire dec_pos;
    wire dec_neg;

    rx_line_decoder u_decoder (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .step_i(sym_rise),
        .pos_i(ja_on ? ja_rd[1] : src_pos),
        .neg_i(ja_on ? ja_rd[0] : src_neg),
        .subst_en_i(dec_mode == `MODE_SUBST),
        .e1_i(E1_MODE_I),
        .data_o(dec_data),
        .cv_o(dec_cv),
        .pos_o(dec_pos),
        .neg_o(dec_neg)
    );

    // ==========================================================
    // System side output stage
    reg nxt_clk;
    reg nxt_dp;
    reg nxt_dn;

    always @*
    begin
        nxt_clk = phase;
        nxt_dp = RX_DATA_POSITIVE_O;
        nxt_dn = RX_DATA_NEGATIVE_O;
        if (edge_rise ? sym_rise : sym_fall)
        begin
            nxt_dp = (dual_rail ? dec_pos : dec_data) ^ data_inv;
            nxt_dn = (dual_rail ? dec_neg : dec_cv) ^ data_inv;
        end
        if (bypass)
        begin
            nxt_dp = src_pos;
            nxt_dn = src_neg;
            nxt_clk = src_pos ^ src_neg;
        end
        if (los_s && alarm_ones)
        begin
            nxt_dp = 1'b1;
            nxt_dn = dual_rail;
            nxt_clk = mclk_s;
        end
        if (power_down)
        begin
            nxt_clk = 1'b0;
            nxt_dp = 1'b0;
            nxt_dn = 1'b0;
        end
    end

    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            src_clk_d_ff <= 1'b0;
            phase_d_ff <= 1'b0;
            acc_ff <= 24'h000000;
            wp_ff <= 8'h00;
            rp_ff <= 8'h00;
            RX_RECOVERED_CLOCK_O <= 1'b0;
            RX_DATA_POSITIVE_O <= 1'b0;
            RX_DATA_NEGATIVE_O <= 1'b0;
            SIGNAL_LOSS_OUT_O <= 1'b0;
            FIRST_CHANNEL_TX_POS_O <= 1'b0;
            FIRST_CHANNEL_TX_NEG_O <= 1'b0;
            RX_TERM_INTERNAL_O <= 1'b0;
            RX_TERM_IMPEDANCE_O <= 2'h0;
            MONITOR_BOOST_SEL_O <= 2'h0;
            EQUALIZER_ENABLE_O <= 1'b0;
            LOS_LEVEL_O <= 5'h00;
            SLICER_THRESHOLD_SEL_O <= 2'h0;
            RX_POWER_DOWN_O <= 1'b0;
        end
        else
        begin
            src_clk_d_ff <= src_clk;
            phase_d_ff <= phase;
            // Proportional loop only: the corner is set by gain, not a true second order filter.
            acc_ff <= acc_ff + inc[23:0];
            wp_ff <= nxt_wp;
            rp_ff <= nxt_rp;
            RX_RECOVERED_CLOCK_O <= nxt_clk;
            RX_DATA_POSITIVE_O <= nxt_dp;
            RX_DATA_NEGATIVE_O <= nxt_dn;
            SIGNAL_LOSS_OUT_O <= los_s & ~power_down;
            FIRST_CHANNEL_TX_POS_O <= monitor_on & remote_loop & nxt_dp;
            FIRST_CHANNEL_TX_NEG_O <= monitor_on & remote_loop & nxt_dn;
            RX_TERM_INTERNAL_O <= ~imp_ff[`IMP_EXTERNAL];
            RX_TERM_IMPEDANCE_O <= imp_ff[`IMP_CODE];
            MONITOR_BOOST_SEL_O <= rx_cfg2_ff[`RCFG2_BOOST];
            EQUALIZER_ENABLE_O <= rx_cfg1_ff[`RCFG1_EQ];
            LOS_LEVEL_O <= rx_cfg1_ff[`RCFG1_LOS_LVL];
            SLICER_THRESHOLD_SEL_O <= rx_cfg2_ff[`RCFG2_SLICER];
            RX_POWER_DOWN_O <= power_down;
        end
    end
endmodule // liu_rx_path
`default_nettype wire

// ---- design/rx_line_decoder.v ----
// Line code decoder with AMI, B8ZS and HDB3 substitution removal.
`timescale 1ns/1ns
`default_nettype none
module rx_line_decoder (
    input wire clk_i,
    input wire rst_i,
    input wire step_i,
    input wire pos_i,
    input wire neg_i,
    input wire subst_en_i,
    input wire e1_i,
    output reg data_o,
    output reg cv_o,
    output reg pos_o,
    output reg neg_o
);
    // ==========================================================
    // Eight-symbol window, slot 0 is the oldest.
    reg [7:0] mark_ff;
    reg [7:0] pol_ff;
    reg [7:0] keep_ff;
    reg last_pol_ff;
    reg seen_ff;
    reg [7:0] nxt_mark;
    reg [7:0] nxt_pol;
    reg [7:0] nxt_keep;
    reg nxt_last;

    always @*
    begin
        nxt_mark = {pos_i | neg_i, mark_ff[7:1]};
        nxt_pol = {pos_i, pol_ff[7:1]};
        nxt_keep = {1'b1, keep_ff[7:1]};
        nxt_last = mark_ff[0] ? pol_ff[0] : last_pol_ff;
        // The B8ZS and 000V rules depend on the last real polarity; the B00V rule compares V with its own B mark.
        if (subst_en_i && !e1_i && (nxt_mark == 8'hD8) && (nxt_pol[3] == nxt_last)
            && (nxt_pol[4] != nxt_pol[3]) && (nxt_pol[6] == nxt_pol[4])
            && (nxt_pol[7] != nxt_pol[6]))
        begin
            nxt_keep = nxt_keep & 8'h27;
        end
        if (subst_en_i && e1_i && (nxt_mark[3:0] == 4'h8) && (nxt_pol[3] == nxt_last))
        begin
            nxt_keep = nxt_keep & 8'hF7;
        end
        if (subst_en_i && e1_i && (nxt_mark[3:0] == 4'h9) && (nxt_pol[3] == nxt_pol[0]))
        begin
            nxt_keep = nxt_keep & 8'hF6;
        end
    end

    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            mark_ff <= 8'h00;
            pol_ff <= 8'h00;
            keep_ff <= 8'h00;
            last_pol_ff <= 1'b0;
            seen_ff <= 1'b0;
            data_o <= 1'b0;
            cv_o <= 1'b0;
            pos_o <= 1'b0;
            neg_o <= 1'b0;
        end
        else if (step_i)
        begin
            data_o <= mark_ff[0] & keep_ff[0];
            cv_o <= mark_ff[0] & keep_ff[0] & seen_ff & (pol_ff[0] == last_pol_ff);
            pos_o <= mark_ff[0] & pol_ff[0];
            neg_o <= mark_ff[0] & ~pol_ff[0];
            seen_ff <= seen_ff | mark_ff[0];
            mark_ff <= nxt_mark;
            pol_ff <= nxt_pol;
            keep_ff <= nxt_keep;
            last_pol_ff <= nxt_last;
        end
    end
endmodule // rx_line_decoder
`default_nettype wire

// ---- inc/liu_rx_defines.vh ----
// Register map, field positions and rate constants for the receive path.
`ifndef LIU_RX_DEFINES_VH
`define LIU_RX_DEFINES_VH

// ==========================================================
// Register offsets
`define ADDR_JA_CFG 8'h01
`define ADDR_RX_CFG0 8'h07
`define ADDR_RX_CFG1 8'h08
`define ADDR_RX_CFG2 8'h09
`define ADDR_MAINT 8'h0A
`define ADDR_INT_STAT1 8'h17
`define ADDR_LINE_IMP 8'h1A
`define ADDR_GLOBAL_CFG1 8'h60
`define REG_RST 8'h00

// ==========================================================
// Field positions
`define JA_PLACE 1:0
`define JA_DEPTH 3:2
`define JA_BW 4
`define JA_CLAMP_BIT 5
`define RCFG0_MODE 1:0
`define RCFG0_INV 2
`define RCFG0_EDGE 3
`define RCFG0_OFF 4
`define RCFG1_LOS_LVL 4:0
`define RCFG1_EQ 5
`define RCFG2_SLICER 1:0
`define RCFG2_BOOST 3:2
`define MAINT_ALARM_ONES 0
`define MAINT_REMOTE_LOOP 1
`define INT_OVF 0
`define INT_UDF 1
`define IMP_EXTERNAL 5
`define IMP_CODE 4:3
`define GCFG1_MONITOR 3:0

// ==========================================================
// Modes and encodings
`define MODE_SUBST 2'h0
`define MODE_AMI 2'h1
`define MODE_BYPASS 2'h3
`define MODE_RAIL_BIT 1
`define JA_PLACE_RX 2'h1
`define DEPTH_SEL_32 2'h0
`define DEPTH_SEL_64 2'h1
`define DEPTH_32 8'h20
`define DEPTH_64 8'h40
`define DEPTH_128 8'h80
`define MARGIN_32 8'h02
`define MARGIN_64 8'h03
`define MARGIN_128 8'h04
`define MONITOR_FIRST 4'h1
`define MONITOR_LAST 4'h6
`define MONITOR_BASE 3'h1
`define SYNC_W 23

// ==========================================================
// Read clock oscillator
`define CLK_HZ 64'hEE6B280
`define E1_RATE_HZ 64'h1F4000
`define T1_RATE_HZ 64'h178F40
`define NCO_ONE 64'h1000000
`define GAIN_E1_NARROW 8'h02
`define GAIN_E1_WIDE 8'h10
`define GAIN_T1_NARROW 8'h03
`define GAIN_T1_WIDE 8'h0C
`define LIMIT_STEP 25'h0004000

`endif

// ---- tb/line_source.sv ----
// Line side pulse source that feeds sliced rails and a line clock to the block.
`timescale 1ns/1ns
`default_nettype none
module line_source #(
    parameter int PH = 7
) (
    input wire logic run_i,
    input wire logic [15:0] pos_pat_i,
    input wire logic [15:0] neg_pat_i,
    output var logic clk_o,
    output var logic pos_o,
    output var logic neg_o
);
    // =========================================================
    // Pattern playback
    int idx = 0;
    initial
    begin
        clk_o = 1'b0;
        pos_o = 1'b0;
        neg_o = 1'b0;
        #PH;
        forever
        begin
            #24;
            if (run_i)
            begin
                clk_o = ~clk_o;
                if (!clk_o)
                begin
                    pos_o = pos_pat_i[idx];
                    neg_o = neg_pat_i[idx];
                    idx = (idx + 1) % 16;
                end
            end
            else
            begin
                // A halted line holds no data, so the rails wander.
                clk_o = 1'b0;
                pos_o = ~pos_o;
                neg_o = ~neg_o;
            end
        end
    end
endmodule // line_source
`default_nettype wire

// ---- tb/liu_rx_path_asserts.sv ----
// Port level assertions for the receive path.
`timescale 1ns/1ns
`default_nettype none
module liu_rx_path_asserts (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic [7:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic [7:0] REG_WDATA_I,
    input wire logic [7:0] REG_RDATA_O,
    input wire logic LOS_DETECT_I,
    input wire logic RX_RECOVERED_CLOCK_O,
    input wire logic RX_DATA_POSITIVE_O,
    input wire logic RX_DATA_NEGATIVE_O,
    input wire logic SIGNAL_LOSS_OUT_O,
    input wire logic RX_TERM_INTERNAL_O,
    input wire logic [1:0] RX_TERM_IMPEDANCE_O,
    input wire logic [1:0] MONITOR_BOOST_SEL_O,
    input wire logic EQUALIZER_ENABLE_O,
    input wire logic [1:0] SLICER_THRESHOLD_SEL_O,
    input wire logic RX_POWER_DOWN_O
);
    // =========================================================
    // Shadow of the mode bits and settle counters
    logic [7:0] cfg0_ff;
    logic [7:0] maint_ff;
    logic [3:0] quiet_ff;
    logic [7:0] los_ff;
    always @(posedge CLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            cfg0_ff <= 8'h00;
            maint_ff <= 8'h00;
            quiet_ff <= 4'h0;
            los_ff <= 8'h00;
        end
        else
        begin
            if (REG_WR_I && REG_ADDR_I == 8'h07)
                cfg0_ff <= REG_WDATA_I;
            if (REG_WR_I && REG_ADDR_I == 8'h0A)
                maint_ff <= REG_WDATA_I;
            // Any write may move the outputs, so relations wait for quiet.
            quiet_ff <= REG_WR_I ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
            if (LOS_DETECT_I && maint_ff[0] && !cfg0_ff[4] && !REG_WR_I)
                los_ff <= los_ff + {7'h00, los_ff != 8'hFF};
            else
                los_ff <= 8'h00;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    term_select_a: assert property (
        REG_WR_I && REG_ADDR_I == 8'h1A |-> ##2 RX_TERM_INTERNAL_O == !$past(REG_WDATA_I[5], 2)
        && RX_TERM_IMPEDANCE_O == $past(REG_WDATA_I[4:3], 2))
        else $error("termination outputs disagree with write");
    boost_slicer_a: assert property (
        REG_WR_I && REG_ADDR_I == 8'h09 |-> ##2 MONITOR_BOOST_SEL_O == $past(REG_WDATA_I[3:2], 2)
        && SLICER_THRESHOLD_SEL_O == $past(REG_WDATA_I[1:0], 2))
        else $error("boost or slicer outputs disagree with write");
    eq_enable_a: assert property (
        REG_WR_I && REG_ADDR_I == 8'h08 |-> ##2 EQUALIZER_ENABLE_O == $past(REG_WDATA_I[5], 2))
        else $error("equalizer enable disagrees with write");
    power_down_a: assert property (
        RX_POWER_DOWN_O [*3] |-> !RX_RECOVERED_CLOCK_O && !RX_DATA_POSITIVE_O
        && !RX_DATA_NEGATIVE_O && !SIGNAL_LOSS_OUT_O)
        else $error("outputs active in power down");
    bypass_xor_a: assert property (
        quiet_ff == 4'hF && cfg0_ff[1:0] == 2'h3 && !maint_ff[0]
        |-> RX_RECOVERED_CLOCK_O == (RX_DATA_POSITIVE_O ^ RX_DATA_NEGATIVE_O))
        else $error("bypass clock is not the rail xor");
    data_edge_a: assert property (
        quiet_ff == 4'hF && cfg0_ff[1:0] != 2'h3 && !maint_ff[0] && !cfg0_ff[4]
        && $changed(RX_DATA_POSITIVE_O)
        |-> $changed(RX_RECOVERED_CLOCK_O) && RX_RECOVERED_CLOCK_O == cfg0_ff[3])
        else $error("data moved off the active clock edge");
    alarm_ones_a: assert property (
        los_ff == 8'hFF |-> RX_DATA_POSITIVE_O && SIGNAL_LOSS_OUT_O)
        else $error("alarm ones not driven during loss");
    sticky_flags_a: assert property (
        REG_ADDR_I == 8'h17 && !REG_WR_I ##1 REG_ADDR_I == 8'h17 && !REG_WR_I
        && |REG_RDATA_O[1:0]
        |=> (REG_RDATA_O[1:0] & $past(REG_RDATA_O[1:0])) == $past(REG_RDATA_O[1:0]))
        else $error("status flag dropped without a clear");
endmodule // liu_rx_path_asserts
bind liu_rx_path liu_rx_path_asserts liu_rx_path_asserts_i (.CLK_I, .RST_I, .REG_ADDR_I,
    .REG_WR_I, .REG_WDATA_I, .REG_RDATA_O, .LOS_DETECT_I, .RX_RECOVERED_CLOCK_O,
    .RX_DATA_POSITIVE_O, .RX_DATA_NEGATIVE_O, .SIGNAL_LOSS_OUT_O, .RX_TERM_INTERNAL_O,
    .RX_TERM_IMPEDANCE_O, .MONITOR_BOOST_SEL_O, .EQUALIZER_ENABLE_O,
    .SLICER_THRESHOLD_SEL_O, .RX_POWER_DOWN_O);
`default_nettype wire

// ---- tb/test_liu_rx_path.sv ----
// Self-checking testbench for the receive path.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module test_liu_rx_path;
    // =========================================================
    // Stimulus and wiring
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic e1 = 1'b0;
    logic mclk = 1'b0;
    logic los = 1'b0;
    logic run = 1'b1;
    logic [15:0] lpos = 16'hAAAA;
    logic [15:0] lneg = 16'h5555;
    wire [7:0] rdata;
    wire lclk, lp, ln, mc, mp, mn, rclk, rp, rn, loss, txp, txn, tint, eq, pd;
    wire [1:0] imp, boost, slicer_threshold_sel;
    wire [4:0] lvl;
    int err_count = 0;
    int checked = 0;
    always #2 clk = ~clk;
    always #20 mclk = ~mclk;
    line_source #(.PH(7)) line_src_i (.run_i(run), .pos_pat_i(lpos), .neg_pat_i(lneg),
        .clk_o(lclk), .pos_o(lp), .neg_o(ln));
    line_source #(.PH(11)) mon_src_i (.run_i(1'b1), .pos_pat_i(16'hFFFF),
        .neg_pat_i(16'h0000), .clk_o(mc), .pos_o(mp), .neg_o(mn));
    liu_rx_path liu_rx_path_i (.CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .E1_MODE_I(e1), .LINE_CLK_I(lclk),
        .LINE_POS_I(lp), .LINE_NEG_I(ln), .MCLK_I(mclk), .LOS_DETECT_I(los),
        .MONITOR_CLK_I({6{mc}}), .MONITOR_POS_I({6{mp}}), .MONITOR_NEG_I({6{mn}}),
        .RX_RECOVERED_CLOCK_O(rclk), .RX_DATA_POSITIVE_O(rp), .RX_DATA_NEGATIVE_O(rn),
        .SIGNAL_LOSS_OUT_O(loss), .FIRST_CHANNEL_TX_POS_O(txp), .FIRST_CHANNEL_TX_NEG_O(txn),
        .RX_TERM_INTERNAL_O(tint), .RX_TERM_IMPEDANCE_O(imp), .MONITOR_BOOST_SEL_O(boost),
        .EQUALIZER_ENABLE_O(eq), .LOS_LEVEL_O(lvl), .SLICER_THRESHOLD_SEL_O(slicer_threshold_sel),
        .RX_POWER_DOWN_O(pd));
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge clk);
        addr <= a;
        repeat (2) @(posedge clk);
        #1;
        `CHK("rdata", e & m, rdata & m)
    endtask
    task automatic settle;
        @(posedge clk);
        #1;
    endtask
    // Outputs are judged across a window, well past the decoder lag.
    task automatic win(input logic [2:0] e, input logic [2:0] m);
        repeat (400) @(posedge clk);
        repeat (12)
        begin
            repeat (7) @(posedge clk);
            #1;
            `CHK("pins", e & m, {rclk, rp, rn} & m)
        end
    endtask
    task automatic cv_seen(input logic e);
        int n;
        n = 0;
        repeat (400) @(posedge clk);
        repeat (800)
        begin
            @(posedge clk);
            #1;
            n += int'(rn === 1'b1);
        end
        `CHK("code error", e, n > 0)
    endtask
    task automatic t_regs;
        logic [7:0] a [8] = '{8'h01, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h17, 8'h1A, 8'h60};
        foreach (a[i]) rd_chk(a[i], 8'h00, 8'hFF);
        wr_reg(8'h02, 8'hFF);
        rd_chk(8'h02, 8'h00, 8'hFF);
        wr_reg(8'h07, 8'h0D);
        rd_chk(8'h07, 8'h0D, 8'hFF);
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(8'h1A, {3'h0, 2'(i), 3'h0});
            settle();
            `CHK("termination", {1'b1, 2'(i)}, {tint, imp})
            wr_reg(8'h09, {4'h0, 2'(i), 2'(i)});
            settle();
            `CHK("boost slicer", {2'(i), 2'(i)}, {boost, slicer_threshold_sel})
        end
        wr_reg(8'h1A, 8'h20);
        wr_reg(8'h08, 8'h35);
        settle();
        `CHK("external and eq", 7'h35, {tint, eq, lvl})
        $display("t_regs done");
    endtask
    task automatic t_decode;
        wr_reg(8'h07, 8'h01);
        win(3'b010, 3'b011);
        wr_reg(8'h07, 8'h05);
        win(3'b000, 3'b010);
        wr_reg(8'h07, 8'h09);
        win(3'b010, 3'b011);
        lpos <= 16'h5511;
        lneg <= 16'hAAA0;
        cv_seen(1'b1);
        wr_reg(8'h07, 8'h00);
        cv_seen(1'b0);
        @(posedge clk);
        e1 <= 1'b1;
        lpos <= 16'h5551;
        cv_seen(1'b0);
        $display("t_decode done");
    endtask
    task automatic t_dual;
        lpos <= 16'h0000;
        lneg <= 16'hFFFF;
        wr_reg(8'h07, 8'h02);
        win(3'b001, 3'b011);
        wr_reg(8'h60, 8'h01);
        wr_reg(8'h0A, 8'h02);
        win(3'b010, 3'b011);
        `CHK("loop pair", 2'b10, {txp, txn})
        wr_reg(8'h60, 8'h00);
        wr_reg(8'h0A, 8'h00);
        lpos <= 16'hFFFF;
        lneg <= 16'h0000;
        wr_reg(8'h07, 8'h03);
        win(3'b110, 3'b111);
        lpos <= 16'hAAAA;
        repeat (400) @(posedge clk);
        $display("t_dual done");
    endtask
    task automatic t_power;
        logic b;
        los <= 1'b1;
        wr_reg(8'h07, 8'h12);
        win(3'b000, 3'b111);
        `CHK("loss and pd", 2'b01, {loss, pd})
        wr_reg(8'h07, 8'h02);
        wr_reg(8'h0A, 8'h01);
        win(3'b011, 3'b011);
        `CHK("loss out", 1'b1, loss)
        b = rclk;
        repeat (5) @(posedge clk);
        #1;
        `CHK("master clock", ~b, rclk)
        wr_reg(8'h0A, 8'h00);
        los <= 1'b0;
        $display("t_power done");
    endtask
    task automatic t_jitter;
        lpos <= 16'hAAAA;
        lneg <= 16'h5555;
        wr_reg(8'h07, 8'h01);
        wr_reg(8'h01, 8'h01);
        repeat (3000) @(posedge clk);
        rd_chk(8'h17, 8'h01, 8'h01);
        rd_chk(8'h17, 8'h01, 8'h01);
        wr_reg(8'h01, 8'h02);
        wr_reg(8'h17, 8'h03);
        rd_chk(8'h17, 8'h00, 8'h03);
        run <= 1'b0;
        wr_reg(8'h01, 8'h29);
        repeat (25000) @(posedge clk);
        rd_chk(8'h17, 8'h02, 8'h02);
        run <= 1'b1;
        wr_reg(8'h01, 8'h00);
        wr_reg(8'h17, 8'h03);
        $display("t_jitter done");
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_decode();
        t_dual();
        t_power();
        t_jitter();
        conclude();
    end
    // A hang is cut short here and counted against the run.
    initial
    begin
        #380000;
        err_count++;
        conclude();
    end
endmodule // test_liu_rx_path
`default_nettype wire
